/* File: rtl/cdl_lock_ctrl.sv */
// Lock detector, reference selection and output mode control.
`timescale 1ns/1ps
module cdl_lock_ctrl
  import cdl_pkg::*;
(
  // Clock and reset
  input  wire logic                      coreClk,
  input  wire logic                      arstN,
  // Asynchronous pins
  input  wire cdl_pkg::cdl_pins_t        pins,
  // Register port
  input  wire logic [cdl_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [cdl_pkg::DATA_W-1:0] regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [cdl_pkg::DATA_W-1:0] regRdata,
  // Status pins and interrupt
  output logic                           lockLostFlag,
  output logic                           signalLostOut,
  output logic                           irq,
  // Analog path control
  output cdl_pkg::cdl_path_t             pathCtrl
);

  // ***************************************************************
  // State
  // ***************************************************************
  // The registered copy of this record drives every output.
  typedef struct packed {
    cdl_loop_t              loop;
    logic [REF_CNT_W-1:0]   refCnt;
    logic [CNT_W-1:0]       vcoCnt;
    logic [CNT_W-1:0]       lastCnt;
    logic                   refPrev;
    logic                   vcoPrev;
    logic                   lockLost;
    logic                   sigLost;
    logic                   clash;
    logic                   swSquelch;
    logic [INT_W-1:0]       intStat;
    logic [INT_W-1:0]       intMask;
    logic                   irq;
    logic [DATA_W-1:0]      rdata;
    cdl_path_t              path;
  } cdl_state_t;

  cdl_state_t state_r;
  cdl_state_t state_nxt;
  cdl_pins_t  pinSync;

  // ***************************************************************
  // Pin synchroniser
  // ***************************************************************
  // Levels and tick waves share one synchroniser, so their relative
  // timing survives; all logic below sees the pins two cycles late.
  cdl_sync #(
    .WIDTH   (PINS_W)
  ) u_sync (
    .coreClk (coreClk),
    .arstN   (arstN),
    .asyncIn (pins),
    .syncOut (pinSync)
  );

  // ***************************************************************
  // Next state
  // ***************************************************************
  logic                 refLevel;
  logic                 refEdge;
  logic                 vcoEdge;
  logic [1:0]           divShift;
  logic [REF_CNT_W-1:0] windowEnd;
  logic [CNT_W-1:0]     winCnt;
  logic [CNT_W-1:0]     freqErr;
  logic                 windowDone;
  logic [INT_W-1:0]     events;
  logic [INT_W-1:0]     clrBits;
  logic                 squelch;
  cdl_status_t          status;

  always_comb begin
    state_nxt = state_r;
    events    = '0;
    clrBits   = '0;

    // ***************************************************************
    // Reference selection
    // ***************************************************************
    // Reference source and division ratio.
    if (pinSync.refSourceSelect) begin
      refLevel = pinSync.refClockTick;
      case (pinSync.refFreqCode)
        FREQ_19M44:  divShift = DIV_SHIFT_1;
        FREQ_38M88:  divShift = DIV_SHIFT_2;
        FREQ_77M76:  divShift = DIV_SHIFT_4;
        FREQ_155M52: divShift = DIV_SHIFT_8;
        default:     divShift = DIV_SHIFT_1;
      endcase
    end else begin
      // The crystal runs at 19.44 MHz and the code pins are ignored.
      refLevel = pinSync.crystalTick;
      divShift = DIV_SHIFT_1;
    end

    // The window holds a fixed time whatever the reference frequency,
    // so the same limits serve all four reference frequencies.
    windowEnd = REF_CNT_W'({1'b0, WINDOW_BASE} << divShift);
    refEdge   = refLevel & ~state_r.refPrev;
    vcoEdge   = pinSync.vcoDivTick & ~state_r.vcoPrev;
    state_nxt.refPrev = refLevel;
    state_nxt.vcoPrev = pinSync.vcoDivTick;

    // ***************************************************************
    // Frequency window
    // ***************************************************************
    // Frequency measurement over a window of reference edges.
    winCnt = state_r.vcoCnt;
    // The count saturates, so a runaway oscillator reads as a large error.
    if (vcoEdge && state_r.vcoCnt != CNT_MAX) begin
      winCnt = state_r.vcoCnt + 1'b1;
    end
    // A window closes at or past its end, so a code change that shortens
    // the window cannot leave the reference counter running to wrap.
    windowDone = refEdge && (state_r.refCnt + 1'b1 >= windowEnd);
    if (winCnt >= WINDOW_BASE) begin
      freqErr = winCnt - WINDOW_BASE;
    end else begin
      freqErr = WINDOW_BASE - winCnt;
    end
    state_nxt.vcoCnt = winCnt;
    if (refEdge) begin
      state_nxt.refCnt = state_r.refCnt + 1'b1;
    end
    if (windowDone) begin
      state_nxt.refCnt  = '0;
      state_nxt.vcoCnt  = '0;
      state_nxt.lastCnt = winCnt;
    end

    // ***************************************************************
    // Loop hand over
    // ***************************************************************
    // Hand the oscillator between the frequency and phase loops.
    case (state_r.loop)
      LOOP_FREQ: begin
        // Only a closed window is judged; a partial count never locks.
        if (windowDone && freqErr <= LOCK_ERR_MAX) begin
          state_nxt.loop     = LOOP_PHASE;
          state_nxt.lockLost = 1'b0;
          events[INT_LOCK_GAINED] = 1'b1;
        end
      end
      LOOP_PHASE: begin
        // Drift without data brings the detector back here repeatedly.
        if (windowDone && freqErr > UNLOCK_ERR_MIN) begin
          state_nxt.loop     = LOOP_FREQ;
          state_nxt.lockLost = 1'b1;
          events[INT_LOCK_LOST] = 1'b1;
        end
      end
      default: begin
        // An illegal loop code falls back to the frequency loop.
        state_nxt.loop     = LOOP_FREQ;
        state_nxt.lockLost = 1'b1;
      end
    endcase

    // ***************************************************************
    // Signal loss and mode clash
    // ***************************************************************
    // Loss of signal follows the comparator through the synchroniser.
    state_nxt.sigLost = pinSync.levelBelowThr;
    if (pinSync.levelBelowThr && !state_r.sigLost) begin
      events[INT_SIG_LOST] = 1'b1;
    end
    // Bypass with loopback is illegal for the system; flag its rise once.
    state_nxt.clash = pinSync.bypassIn & pinSync.loopbackEnable;
    if (state_nxt.clash && !state_r.clash) begin
      events[INT_MODE_CLASH] = 1'b1;
    end

    // ***************************************************************
    // Output path
    // ***************************************************************
    // Output path control.
    squelch = pinSync.squelchIn | state_r.swSquelch;
    state_nxt.path.rateFec          =
      (pinSync.lineRateSel == RATE_FEC);
    state_nxt.path.useCrystal       = ~pinSync.refSourceSelect;
    state_nxt.path.refDivShift      = divShift;
    state_nxt.path.phaseLoopEn      = state_nxt.loop == LOOP_PHASE;
    state_nxt.path.clkOutZero       = squelch;
    state_nxt.path.dataOutZero      = squelch;
    state_nxt.path.quantToOutput    = pinSync.bypassIn;
    state_nxt.path.cdrFromTestInput = pinSync.loopbackEnable;

    // ***************************************************************
    // Register writes
    // ***************************************************************
    // Writes take effect at the next edge; unmapped writes are ignored.
    if (regWr) begin
      if (regAddr == CTRL_OFS) begin
        state_nxt.swSquelch = regWdata[CTRL_SW_SQUELCH_BIT];
      end else if (regAddr == INT_STAT_OFS) begin
        clrBits = regWdata[INT_W-1:0];
      end else if (regAddr == INT_MASK_OFS) begin
        state_nxt.intMask = regWdata[INT_W-1:0];
      end
    end

    // ***************************************************************
    // Interrupts
    // ***************************************************************
    // A new event wins over a clear in the same cycle.
    state_nxt.intStat = (state_r.intStat & ~clrBits) | events;
    state_nxt.irq     = |(state_nxt.intStat & state_nxt.intMask);

    // ***************************************************************
    // Register reads
    // ***************************************************************
    // Register reads: data stand for one cycle only.
    // Mode and code fields read the synchronised pins directly, except the line rate, which reads the registered path.
    status.loopback        = pinSync.loopbackEnable;
    status.bypass          = pinSync.bypassIn;
    status.rateFec         = state_r.path.rateFec;
    status.refFreqCode     = pinSync.refFreqCode;
    status.refSourceSelect = pinSync.refSourceSelect;
    status.phaseLoopEn     = state_r.path.phaseLoopEn;
    status.signalLost      = state_r.sigLost;
    status.lockLost        = state_r.lockLost;
    // Unmapped addresses and idle cycles read as zero.
    state_nxt.rdata = '0;
    if (regRd) begin
      if (regAddr == CTRL_OFS) begin
        state_nxt.rdata = DATA_W'(state_r.swSquelch);
      end else if (regAddr == STATUS_OFS) begin
        state_nxt.rdata = DATA_W'(status);
      end else if (regAddr == INT_STAT_OFS) begin
        state_nxt.rdata = DATA_W'(state_r.intStat);
      end else if (regAddr == INT_MASK_OFS) begin
        state_nxt.rdata = DATA_W'(state_r.intMask);
      end else if (regAddr == LAST_CNT_OFS) begin
        state_nxt.rdata = DATA_W'(state_r.lastCnt);
      end
    end
  end

  // ***************************************************************
  // State register
  // ***************************************************************
  always_ff @(posedge coreClk or negedge arstN) begin
    if (!arstN) begin
      // Loss of lock stands out of reset until a first window locks.
      state_r.loop      <= LOOP_FREQ;
      state_r.refCnt    <= '0;
      state_r.vcoCnt    <= '0;
      state_r.lastCnt   <= '0;
      state_r.refPrev   <= 1'b0;
      state_r.vcoPrev   <= 1'b0;
      state_r.lockLost  <= 1'b1;
      state_r.sigLost   <= 1'b0;
      state_r.clash     <= 1'b0;
      state_r.swSquelch <= CTRL_SW_SQUELCH_RST;
      state_r.intStat   <= INT_RST;
      state_r.intMask   <= INT_RST;
      state_r.irq       <= 1'b0;
      state_r.rdata     <= '0;
      state_r.path      <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  // Every output is a field of the registered state.
  assign regRdata      = state_r.rdata;
  assign lockLostFlag  = state_r.lockLost;
  assign signalLostOut = state_r.sigLost;
  assign irq           = state_r.irq;
  assign pathCtrl      = state_r.path;

endmodule

/* File: rtl/cdl_pkg.sv */
// Constants, register map and types for the lock and mode control block.
package cdl_pkg;

  // ***************************************************************
  // Register bus
  // ***************************************************************
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS      = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h04;
  localparam logic [ADDR_W-1:0] INT_STAT_OFS  = 8'h08;
  localparam logic [ADDR_W-1:0] INT_MASK_OFS  = 8'h0C;
  localparam logic [ADDR_W-1:0] LAST_CNT_OFS  = 8'h10;

  // ***************************************************************
  // Control register layout
  // ***************************************************************
  localparam int unsigned CTRL_SW_SQUELCH_BIT = 0;
  localparam logic        CTRL_SW_SQUELCH_RST = 1'b0;

  // ***************************************************************
  // Interrupt bits, shared by status and mask
  // ***************************************************************
  localparam int unsigned INT_W            = 4;
  localparam int unsigned INT_LOCK_LOST    = 0;
  localparam int unsigned INT_LOCK_GAINED  = 1;
  localparam int unsigned INT_SIG_LOST     = 2;
  localparam int unsigned INT_MODE_CLASH   = 3;
  localparam logic [INT_W-1:0] INT_RST     = 4'h0;

  // ***************************************************************
  // Line rate and reference selection
  // ***************************************************************
  localparam real     RATE_NATIVE_MHZ = 2488.32;
  localparam real     RATE_FEC_MHZ    = 2666.06;
  localparam logic    RATE_NATIVE     = 1'b0;
  localparam logic    RATE_FEC        = 1'b1;
  localparam real     XTAL_MHZ        = 19.44;
  localparam logic [1:0] FREQ_19M44   = 2'h0;
  localparam logic [1:0] FREQ_38M88   = 2'h1;
  localparam logic [1:0] FREQ_77M76   = 2'h2;
  localparam logic [1:0] FREQ_155M52  = 2'h3;
  // Division ratio as a power of two: 1, 2, 4 or 8 times 19.44 MHz.
  localparam logic [1:0] DIV_SHIFT_1  = 2'h0;
  localparam logic [1:0] DIV_SHIFT_2  = 2'h1;
  localparam logic [1:0] DIV_SHIFT_4  = 2'h2;
  localparam logic [1:0] DIV_SHIFT_8  = 2'h3;

  // ***************************************************************
  // Lock detector
  // ***************************************************************
  localparam int unsigned CNT_W       = 16;
  localparam int unsigned REF_CNT_W   = 17;
  localparam int unsigned PPM_SCALE   = 1000000;
  localparam int unsigned LOCK_PPM    = 500;
  localparam int unsigned UNLOCK_PPM  = 1000;
  // Nominal divided oscillator count per window at 19.44 MHz reference.
  localparam logic [CNT_W-1:0] WINDOW_BASE = 16'h2710;
  localparam logic [CNT_W-1:0] LOCK_ERR_MAX =
    CNT_W'(int'(WINDOW_BASE) * LOCK_PPM / PPM_SCALE);
  localparam logic [CNT_W-1:0] UNLOCK_ERR_MIN =
    CNT_W'(int'(WINDOW_BASE) * UNLOCK_PPM / PPM_SCALE);
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_PS   = 5000;
  localparam int unsigned LOS_RESP_NS     = 300;
  localparam int unsigned LOS_RESP_CYCLES =
    (LOS_RESP_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned SYNC_STAGES     = 2;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [1:0] {
    LOOP_FREQ  = 2'b01,
    LOOP_PHASE = 2'b10
  } cdl_loop_t;

  // Pins from the analog side and the system, all asynchronous.
  typedef struct packed {
    logic       lineRateSel;
    logic       refSourceSelect;
    logic [1:0] refFreqCode;
    logic       squelchIn;
    logic       bypassIn;
    logic       loopbackEnable;
    logic       levelBelowThr;
    logic       refClockTick;
    logic       crystalTick;
    logic       vcoDivTick;
  } cdl_pins_t;

  localparam int unsigned PINS_W = $bits(cdl_pins_t);

  // Control of the analog recovery path.
  typedef struct packed {
    logic       rateFec;
    logic       useCrystal;
    logic [1:0] refDivShift;
    logic       phaseLoopEn;
    logic       clkOutZero;
    logic       dataOutZero;
    logic       quantToOutput;
    logic       cdrFromTestInput;
  } cdl_path_t;

  // Read layout of the status register.
  typedef struct packed {
    logic       loopback;
    logic       bypass;
    logic       rateFec;
    logic [1:0] refFreqCode;
    logic       refSourceSelect;
    logic       phaseLoopEn;
    logic       signalLost;
    logic       lockLost;
  } cdl_status_t;

endpackage

/* File: rtl/cdl_sync.sv */
// Two flip-flop synchroniser for a group of asynchronous levels.
`timescale 1ns/1ps
module cdl_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             coreClk,
  input  wire logic             arstN,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge coreClk or negedge arstN) begin
    if (!arstN) begin
      meta_r  <= '0;
      syncOut <= '0;
    end else begin
      meta_r  <= asyncIn;
      syncOut <= meta_r;
    end
  end

endmodule

/* File: dv/cdl_lock_ctrl_checker.sv */
// Assertion checker for the lock and mode control block.
`timescale 1ns/1ps
module cdl_lock_ctrl_checker
  import cdl_pkg::*;
(
  // Clock and reset
  input wire logic                        coreClk,
  input wire logic                        arstN,
  // Observed ports
  input wire cdl_pkg::cdl_pins_t          pins,
  input wire logic                        regRd,
  input wire logic [cdl_pkg::DATA_W-1:0]  regRdata,
  input wire logic                        lockLostFlag,
  input wire logic                        signalLostOut,
  input wire cdl_pkg::cdl_path_t          pathCtrl
);
  // ***********************************************************
  // Settling counter and sequences
  // ***********************************************************
  logic [2:0] settle_r;
  always_ff @(posedge coreClk or negedge arstN) begin
    if (!arstN) settle_r <= 3'h0;
    else if (settle_r != 3'h7) settle_r <= settle_r + 3'h1;
  end
  default clocking cb @(posedge coreClk); endclocking
  default disable iff (!arstN);
  // Outputs follow the pins three cycles late once the pipeline fills.
  sequence settled; settle_r == 3'h7; endsequence
  sequence squelchSeen; pins.squelchIn ##3 1'b1; endsequence
  sig_lost_a: assert property (
    settled |-> signalLostOut == $past(pins.levelBelowThr, 3))
    else $error("signal lost output does not follow level");
  rate_sel_a: assert property (
    settled |-> pathCtrl.rateFec == $past(pins.lineRateSel, 3))
    else $error("line rate control does not follow pin");
  squelch_zero_a: assert property (
    squelchSeen ##0 settled |-> pathCtrl.clkOutZero && pathCtrl.dataOutZero)
    else $error("squelch did not zero the outputs");
  bypass_route_a: assert property (
    settled |-> pathCtrl.quantToOutput == $past(pins.bypassIn, 3))
    else $error("bypass routing does not follow pin");
  loop_route_a: assert property (
    settled |-> pathCtrl.cdrFromTestInput == $past(pins.loopbackEnable, 3))
    else $error("loopback routing does not follow pin");
  crystal_sel_a: assert property (
    settled ##0 !$past(pins.refSourceSelect, 3) |->
      pathCtrl.useCrystal && pathCtrl.refDivShift == 2'h0)
    else $error("crystal source not applied");
  ref_div_a: assert property (
    settled ##0 $past(pins.refSourceSelect, 3) |-> !pathCtrl.useCrystal &&
      pathCtrl.refDivShift == $past(pins.refFreqCode, 3))
    else $error("reference division does not match code");
  loop_excl_a: assert property (
    lockLostFlag != pathCtrl.phaseLoopEn)
    else $error("phase loop and lock flag disagree");
  rdata_idle_a: assert property (
    !$past(regRd) |-> regRdata == 32'h0000_0000)
    else $error("read data present without a read");
endmodule
bind cdl_lock_ctrl cdl_lock_ctrl_checker chk (.coreClk(coreClk),
  .arstN(arstN), .pins(pins), .regRd(regRd), .regRdata(regRdata),
  .lockLostFlag(lockLostFlag), .signalLostOut(signalLostOut),
  .pathCtrl(pathCtrl));

/* File: dv/cdl_front_model.sv */
// Free running reference, crystal and divided oscillator waves.
`timescale 1ns/1ps
module cdl_front_model #(
  parameter int unsigned REF_HALF = 3,
  parameter int unsigned VCO_HALF = 3
) (
  // Clock
  input wire logic coreClk,
  // Tick waves
  output logic     refClockTick,
  output logic     crystalTick,
  output logic     vcoDivTick
);
  int refCnt = 0;
  int vcoCnt = 0;
  initial begin
    refClockTick = 1'b0;
    crystalTick = 1'b0;
    vcoDivTick = 1'b0;
  end
  // Reference and crystal share one exact rate, well inside 100 ppm.
  always @(posedge coreClk) begin
    refCnt <= (refCnt == REF_HALF - 1) ? 0 : refCnt + 1;
    vcoCnt <= (vcoCnt == VCO_HALF - 1) ? 0 : vcoCnt + 1;
    if (refCnt == REF_HALF - 1) begin
      refClockTick <= ~refClockTick;
      crystalTick <= ~crystalTick;
    end
    if (vcoCnt == VCO_HALF - 1) vcoDivTick <= ~vcoDivTick;
  end
endmodule

/* File: dv/tb_cdr_lock_and_mode_control.sv */
// Self-checking testbench for the lock and mode control block.
`timescale 1ns/1ps
module tb_cdr_lock_and_mode_control;
  import cdl_pkg::*;
  logic              coreClk, arstN, regWr, regRd;
  logic [ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0] regWdata, regRdata, rd;
  logic              lockLostFlag, signalLostOut, irq;
  logic              refTick, xtalTick, vcoTick;
  cdl_path_t         pathCtrl;
  cdl_pins_t         pinsDrv, pins;
  int                errTotal = 0;
  int                nTests = 0;
  int                cyc = 0;
  assign pins = cdl_pins_t'({pinsDrv[PINS_W-1:3], refTick, xtalTick, vcoTick});
  cdl_front_model FM (.coreClk(coreClk), .refClockTick(refTick),
    .crystalTick(xtalTick), .vcoDivTick(vcoTick));
  cdl_lock_ctrl DUT (.coreClk(coreClk), .arstN(arstN), .pins(pins),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .lockLostFlag(lockLostFlag),
    .signalLostOut(signalLostOut), .irq(irq), .pathCtrl(pathCtrl));
  // ***********************************************************
  // Tasks
  // ***********************************************************
  task automatic stopTest();
    $display("Checks %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic regWrite(logic [7:0] a, logic [31:0] d);
    @(posedge coreClk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge coreClk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(logic [7:0] a);
    @(posedge coreClk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge coreClk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  task automatic settle();
    repeat (5) @(posedge coreClk);
    #1;
  endtask
  initial begin
    coreClk = 1'b0;
    forever #2.5 coreClk = ~coreClk;
  end
  always @(posedge coreClk) begin
    cyc++;
    if (cyc == 90000) begin
      errTotal++;
      stopTest();
    end
  end
  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    arstN = 1'b0;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 8'h00;
    regWdata = 32'h0000_0000;
    pinsDrv = '0;
    pinsDrv.refSourceSelect = 1'b1;
    pinsDrv.squelchIn = 1'b0;
    repeat (2) @(posedge coreClk);
    arstN <= 1'b1;
    #1;
    check("lockLostRst", 32'h1, 32'(lockLostFlag));
    check("irqRst", 32'h0, 32'(irq));
    regRead(INT_MASK_OFS);
    check("maskRst", 32'h0, rd);
    // Same-rate oscillator must clear loss of lock after one window.
    while (lockLostFlag !== 1'b0) @(posedge coreClk);
    #1;
    check("phaseLoop", 32'h1, 32'(pathCtrl.phaseLoopEn));
    regRead(LAST_CNT_OFS);
    check("cntNear", 32'h1, 32'(rd >= 9995 && rd <= 10005));
    regRead(INT_STAT_OFS);
    check("gainedEvt", 32'h1, 32'(rd[INT_LOCK_GAINED]));
    for (int i = 0; i < 16; i++) begin
      @(posedge coreClk);
      {pinsDrv.lineRateSel, pinsDrv.refSourceSelect,
       pinsDrv.refFreqCode} <= 4'(i);
      settle();
      check("rateFec", 32'(i[3]), 32'(pathCtrl.rateFec));
      check("useXtal", 32'(!i[2]), 32'(pathCtrl.useCrystal));
      check("divShift", i[2] ? 32'(i[1:0]) : 32'h0,
        32'(pathCtrl.refDivShift));
      regRead(STATUS_OFS);
      check("statCode", 32'(i[1:0]), 32'(rd[5:4]));
    end
    for (int j = 0; j < 4; j++) begin
      @(posedge coreClk);
      {pinsDrv.squelchIn, pinsDrv.bypassIn,
       pinsDrv.loopbackEnable} <= 3'(4 >> j);
      settle();
      check("clkZero", 32'(j == 0), 32'(pathCtrl.clkOutZero));
      check("datZero", 32'(j == 0), 32'(pathCtrl.dataOutZero));
      check("bypass", 32'(j == 1), 32'(pathCtrl.quantToOutput));
      check("loopback_enable", 32'(j == 2), 32'(pathCtrl.cdrFromTestInput));
    end
    regWrite(CTRL_OFS, 32'h0000_0001);
    regRead(CTRL_OFS);
    check("ctrlRd", 32'h1, rd);
    check("swSquelch", 32'h1, 32'(pathCtrl.clkOutZero));
    regWrite(CTRL_OFS, 32'h0000_0000);
    regRead(8'h20);
    check("unmapped", 32'h0, rd);
    @(posedge coreClk);
    pinsDrv.levelBelowThr <= 1'b1;
    settle();
    check("sigLost", 32'h1, 32'(signalLostOut));
    check("irqMasked", 32'h0, 32'(irq));
    regRead(INT_STAT_OFS);
    check("lostEvt", 32'h1, 32'(rd[INT_SIG_LOST]));
    regWrite(INT_MASK_OFS, 32'h0000_0004);
    settle();
    check("irqOn", 32'h1, 32'(irq));
    regWrite(INT_STAT_OFS, 32'h0000_0004);
    settle();
    check("irqClr", 32'h0, 32'(irq));
    @(posedge coreClk);
    pinsDrv.levelBelowThr <= 1'b0;
    settle();
    check("sigBack", 32'h0, 32'(signalLostOut));
    stopTest();
  end
endmodule
